/* File: hdl/wut_pkg.sv */
// Function
// - Counter is clocked from the slow RC oscillator or the 32 kHz crystal.
// - Counter overflow sets the overflow flag at bit 7.
// - Taking the wake-up interrupt vector clears the overflow flag.
// - Writing one to the overflow flag clears it; zero leaves it.
// - Wake-up interrupt is requested only while global enable, bit 6 and flag are set.
// - With both enables set, an overflow makes the interrupt be taken.
// - Calibration flag at bit 5 sets every 256 RC or 64 crystal cycles.
// - Writing one clears the calibration flag; vector execution does not.
// - Writing one to bit 4 restarts the counter from zero.
// - The counter restart bit stores nothing and always reads zero.
// - Bit 3 runs the timer when set and stops it when cleared.
// - RC source period is 4096 cycles at 000, doubling up to 524288.
// - Crystal source period is 1024 cycles at 000, doubling up to 131072.
// - The overflow interrupt uses vector 10 at address 0x0012.
`default_nettype none

package wut_pkg;

    localparam logic [7:0] WUT_CSR_OFS      = 8'h00;
    localparam logic [7:0] WUT_IRQ_STAT_OFS = 8'h04;
    localparam logic [7:0] WUT_IRQ_CLR_OFS  = 8'h08;
    localparam logic [7:0] WUT_IRQ_EN_OFS   = 8'h0c;
    localparam logic [7:0] WUT_SRC_OFS      = 8'h10;

    localparam int WUT_OVF_BIT  = 7;
    localparam int WUT_IE_BIT   = 6;
    localparam int WUT_CAL_BIT  = 5;
    localparam int WUT_CLR_BIT  = 4;
    localparam int WUT_RUN_BIT  = 3;
    localparam int WUT_PSEL_LSB = 0;
    localparam int WUT_PSEL_W   = 3;
    localparam int WUT_SRC_BIT  = 0;

    localparam int WUT_EV_OVF = 0;
    localparam int WUT_EV_CAL = 1;
    localparam int WUT_EV_N   = 2;

    localparam int          WUT_CNT_W      = 19;
    localparam logic [18:0] WUT_RC_BASE    = 19'h01000;
    localparam logic [18:0] WUT_XT_BASE    = 19'h00400;
    localparam logic [7:0]  WUT_RC_CAL_LST = 8'hff;
    localparam logic [7:0]  WUT_XT_CAL_LST = 8'h3f;

    localparam logic [7:0]  WUT_CSR_RST    = 8'h00;
    localparam logic [1:0]  WUT_IRQ_RST    = 2'h0;

    localparam logic [4:0]  WUT_VEC_NUM    = 5'h0a;
    localparam logic [15:0] WUT_VEC_ADDR   = 16'h0012;

    typedef enum logic {
        WUT_SRC_RC = 1'b0,
        WUT_SRC_XT = 1'b1
    } wut_src_t;

    typedef struct packed {
        logic       ie;
        logic       run;
        logic [2:0] psel;
    } wut_ctrl_t;

endpackage

`default_nettype wire

/* File: hdl/wut_edge_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module wut_edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Asynchronous level in, one-cycle rising-edge pulse out
    input  wire logic async_in,
    output logic      rise
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // Only the second stage and later are looked at.
    assign rise = sync_r & ~prev_r;

endmodule

`default_nettype wire

/* File: hdl/wut_timer.sv */
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module wut_timer #(
    parameter int CNT_W = wut_pkg::WUT_CNT_W
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,

    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,

    // Slow clock sources, asynchronous to clk
    input  wire logic        slow_rc_osc,
    input  wire logic        xtal_osc,

    // CPU interrupt handshake
    input  wire logic        cpu_global_irq_en,
    input  wire logic        vector_ack,
    output logic             wakeup_irq_req,
    output logic [4:0]       vector_num,
    output logic [15:0]      vector_addr,

    // System interrupt line
    output logic             irq
);

    if (CNT_W < wut_pkg::WUT_CNT_W) begin : g_bad_width
        $error("wut_timer: CNT_W too small for the longest period");
    end

    if (wut_pkg::WUT_PSEL_W != 3) begin : g_bad_psel
        $error("wut_timer: period select must be three bits wide");
    end

    // Register state.
    wut_pkg::wut_ctrl_t    ctrl_r;
    wut_pkg::wut_src_t     src_r;
    logic                  ovf_flag_r;
    logic                  cal_flag_r;
    logic [CNT_W-1:0]      cnt_r;
    logic [7:0]            cal_cnt_r;
    logic [1:0]            irq_stat_r;
    logic [1:0]            irq_en_r;
    logic [31:0]           prdata_r;

    // Next values.
    wut_pkg::wut_ctrl_t    ctrl_nxt;
    wut_pkg::wut_src_t     src_nxt;
    logic                  ovf_flag_nxt;
    logic                  cal_flag_nxt;
    logic [CNT_W-1:0]      cnt_nxt;
    logic [7:0]            cal_cnt_nxt;
    logic [1:0]            irq_stat_nxt;
    logic [1:0]            irq_en_nxt;

    // True when the crystal is the selected source.
    function automatic logic src_is_xt(
        input wut_pkg::wut_src_t src
    );
        return src == wut_pkg::WUT_SRC_XT;
    endfunction

    // Period terminal count for a source and a select value.
    function automatic logic [CNT_W-1:0] period_last(
        input wut_pkg::wut_src_t src,
        input logic [2:0]        psel_v
    );
        logic [CNT_W-1:0] base;
        base = src_is_xt(src) ?
               CNT_W'(wut_pkg::WUT_XT_BASE) :
               CNT_W'(wut_pkg::WUT_RC_BASE);
        return (base << psel_v) - CNT_W'(1);
    endfunction

    // Slow source edges brought into the clk domain.
    logic [1:0] osc_in;
    logic [1:0] osc_rise;

    assign osc_in = {xtal_osc, slow_rc_osc};

    for (genvar i = 0; i < 2; i++) begin : g_sync
        wut_edge_sync u_sync (
            .clk      (clk),
            .rst      (rst),
            .async_in (osc_in[i]),
            .rise     (osc_rise[i])
        );
    end

    // A source edge shows up as a tick two clk edges after the pin rises.
    wire tick = src_is_xt(src_r) ?
                osc_rise[1] : osc_rise[0];

    // Bus decode.
    wire acc     = psel & penable;
    wire wr_en   = acc & pwrite & pstrb[0];
    wire setup   = psel & ~penable;
    wire hit_csr = paddr == wut_pkg::WUT_CSR_OFS;
    wire hit_st  = paddr == wut_pkg::WUT_IRQ_STAT_OFS;
    wire hit_clr = paddr == wut_pkg::WUT_IRQ_CLR_OFS;
    wire hit_en  = paddr == wut_pkg::WUT_IRQ_EN_OFS;
    wire hit_src = paddr == wut_pkg::WUT_SRC_OFS;
    wire hit_any = hit_csr | hit_st | hit_clr | hit_en | hit_src;

    wire wr_csr  = wr_en & hit_csr;
    wire wr_clr  = wr_en & hit_clr;
    wire wr_irq_en = wr_en & hit_en;
    wire wr_src  = wr_en & hit_src;

    wire [7:0] wbyte = pwdata[7:0];

    // Write-one actions on the control/status byte.
    wire csr_ovf_clr = wr_csr & wbyte[wut_pkg::WUT_OVF_BIT];
    wire csr_cal_clr = wr_csr & wbyte[wut_pkg::WUT_CAL_BIT];
    wire cnt_restart = wr_csr & wbyte[wut_pkg::WUT_CLR_BIT];

    // Counter.
    wire [CNT_W-1:0] cnt_last = period_last(src_r, ctrl_r.psel);
    wire cnt_step = ctrl_r.run & tick;
    // A period shrunk below the current count wraps on the next counter step.
    wire cnt_wrap = cnt_r >= cnt_last;
    wire ovf_ev   = cnt_step & cnt_wrap & ~cnt_restart;

    always_comb begin
        if (cnt_restart) begin
            cnt_nxt = '0;
        end else if (cnt_step) begin
            cnt_nxt = cnt_wrap ? '0 : cnt_r + CNT_W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    // Calibration divider runs on every rising edge of the chosen source.
    wire [7:0] cal_last = src_is_xt(src_r) ?
                          wut_pkg::WUT_XT_CAL_LST :
                          wut_pkg::WUT_RC_CAL_LST;
    wire cal_wrap = cal_cnt_r >= cal_last;
    wire cal_ev   = tick & cal_wrap;

    always_comb begin
        if (tick) begin
            cal_cnt_nxt = cal_wrap ? 8'h00 : cal_cnt_r + 8'h01;
        end else begin
            cal_cnt_nxt = cal_cnt_r;
        end
    end

    // Flags: a set in the same cycle as a clear wins.
    // Taking the vector clears the flag only; the sticky status stays.
    wire ovf_clr = csr_ovf_clr | vector_ack;

    assign ovf_flag_nxt = ovf_ev | (ovf_flag_r & ~ovf_clr);
    assign cal_flag_nxt = cal_ev | (cal_flag_r & ~csr_cal_clr);

    // Control fields.
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_csr) begin
            ctrl_nxt.ie   = wbyte[wut_pkg::WUT_IE_BIT];
            ctrl_nxt.run  = wbyte[wut_pkg::WUT_RUN_BIT];
            ctrl_nxt.psel = wbyte[wut_pkg::WUT_PSEL_LSB +:
                                  wut_pkg::WUT_PSEL_W];
        end
    end

    assign src_nxt = wr_src ?
                     wut_pkg::wut_src_t'(wbyte[wut_pkg::WUT_SRC_BIT]) :
                     src_r;

    // Sticky event status, write-one clear, enable mask.
    wire [1:0] ev_vec = {cal_ev, ovf_ev};
    wire [1:0] st_clr = wr_clr ? wbyte[1:0] : 2'h0;

    for (genvar e = 0; e < wut_pkg::WUT_EV_N; e++) begin : g_stat
        assign irq_stat_nxt[e] = ev_vec[e] | (irq_stat_r[e] & ~st_clr[e]);
    end
    assign irq_en_nxt = wr_irq_en ? wbyte[1:0] : irq_en_r;

    // Read view of the control/status byte.
    wire [7:0] csr_view = {
        ovf_flag_r,
        ctrl_r.ie,
        cal_flag_r,
        1'b0,
        ctrl_r.run,
        ctrl_r.psel
    };

    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_csr) begin
            rd_byte = csr_view;
        end else if (hit_st) begin
            rd_byte = {6'h00, irq_stat_r};
        end else if (hit_en) begin
            rd_byte = {6'h00, irq_en_r};
        end else if (hit_src) begin
            rd_byte = {7'h00, src_is_xt(src_r)};
        end
    end

    // State registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovf_flag_r <= 1'b0;
        end else begin
            ovf_flag_r <= ovf_flag_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_flag_r <= 1'b0;
        end else begin
            cal_flag_r <= cal_flag_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_r <= wut_pkg::WUT_SRC_RC;
        end else begin
            src_r <= src_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_cnt_r <= 8'h00;
        end else begin
            cal_cnt_r <= cal_cnt_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= wut_pkg::WUT_IRQ_RST;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_en_r <= wut_pkg::WUT_IRQ_RST;
        end else begin
            irq_en_r <= irq_en_nxt;
        end
    end

    // Read data is caught in the setup cycle and held for the access.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            prdata_r <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
        end
    end

    // Bus answers.
    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = acc & ~hit_any;

    // Interrupt outputs.
    assign wakeup_irq_req = cpu_global_irq_en & ctrl_r.ie
                            & ovf_flag_r;
    assign vector_num     = wut_pkg::WUT_VEC_NUM;
    assign vector_addr    = wut_pkg::WUT_VEC_ADDR;
    assign irq            = |(irq_stat_r & irq_en_r);

endmodule

`default_nettype wire

/* File: tb/wut_timer_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module wut_mon (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Interrupt side
    input wire logic        cpu_global_irq_en,
    input wire logic        vector_ack,
    input wire logic        wakeup_irq_req,
    input wire logic [4:0]  vector_num,
    input wire logic [15:0] vector_addr,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr;
        psel && penable && pwrite && pstrb[0] && paddr == 8'h00;
    endsequence
    sequence s_rd;
        psel && penable && !pwrite && paddr == 8'h00;
    endsequence
    a_req_needs_gie: assert property (
        wakeup_irq_req |-> cpu_global_irq_en)
        else $error("request without global enable");
    a_ie_masks_req: assert property (
        s_wr ##0 !pwdata[6] |=> !wakeup_irq_req)
        else $error("request with enable cleared");
    a_ack_clears_ovf: assert property (vector_ack |=> !wakeup_irq_req)
        else $error("vector taken but flag kept");
    a_w1c_ovf_flag: assert property (
        s_wr ##0 pwdata[7] |=> !wakeup_irq_req)
        else $error("flag not cleared by write");
    a_req_sticky: assert property (wakeup_irq_req && !vector_ack
        && !(psel && pwrite) |=> wakeup_irq_req || !cpu_global_irq_en)
        else $error("flag dropped by itself");
    a_clr_reads_zero: assert property (s_rd |-> !prdata[4])
        else $error("restart bit read as one");
    a_vector_fixed: assert property (
        vector_num == 5'h0a && vector_addr == 16'h0012)
        else $error("wrong vector");
    a_reset_clear: assert property ($fell(rst) |->
        prdata == 32'h0 && !irq && !wakeup_irq_req)
        else $error("not clear after reset");
    a_unmapped_err: assert property (
        psel && penable && paddr == 8'h14 |-> pslverr)
        else $error("no error on unmapped access");
endmodule
bind wut_timer wut_mon i_wut_mon (.clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pslverr, .cpu_global_irq_en,
    .vector_ack, .wakeup_irq_req, .vector_num, .vector_addr, .irq);
`default_nettype wire

/* File: tb/wakeup_interval_timer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module wakeup_interval_timer_tb_top;
    logic        clk = 0, rst = 1, psel = 0, penable = 0;
    logic        pwrite = 0, rc = 0, xt = 0, gie = 0, ack = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0;
    logic [3:0]  pstrb = 0;
    logic [31:0] prdata;
    logic        pready, pslverr, req, irq, sel_xt = 0;
    logic [31:0] expq[$];
    int          err_total = 0, num_checks = 0;
    always #5 clk = ~clk;
    wut_timer i_wut_timer (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .slow_rc_osc(rc),
        .xtal_osc(xt), .cpu_global_irq_en(gie), .vector_ack(ack),
        .wakeup_irq_req(req), .vector_num(), .vector_addr(), .irq);
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Read data is compared against the oldest noted expectation.
    always @(posedge clk)
        if (psel && penable && pready && !pwrite)
            chk(prdata, expq.pop_front());
    task automatic apb(logic w, logic [7:0] a, logic [7:0] d,
                       logic [3:0] s = 4'hf);
        int n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'($urandom), d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        do begin
            @(posedge clk);
            n++;
        end while (!pready && n < 16);
        if (!pready) begin
            err_total++;
            end_sim();
        end
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        expq.push_back(e);
        apb(0, a, 8'h00);
    endtask
    // Makes k rising edges on the selected slow source, random phases.
    task automatic run(int k);
        int h;
        repeat (k) begin
            h = 3 + $urandom % 3;
            repeat (h) @(posedge clk);
            {xt, rc} <= sel_xt ? 2'b10 : 2'b01;
            repeat (h) @(posedge clk);
            {xt, rc} <= 2'b00;
        end
        repeat (6) @(posedge clk);
    endtask
    initial begin
        void'($urandom(32'hc019));
        repeat (2) @(posedge clk);
        rst <= 0;
        rd(8'h00, 0);
        rd(8'h04, 0);
        rd(8'h14, 0);
        apb(1, 8'h0c, 8'h03, 4'h0);
        rd(8'h0c, 0);
        $display("test reset done");
        apb(1, 8'h0c, 8'h01);
        gie <= 1;
        apb(1, 8'h00, 8'h58);
        run(255);
        rd(8'h04, 0);
        run(1);
        rd(8'h04, 8'h02);
        run(3839);
        chk(32'(irq), 0);
        run(1);
        chk(32'(req), 1);
        chk(32'(irq), 1);
        rd(8'h00, 8'he8);
        gie <= 0;
        @(posedge clk);
        chk(32'(req), 0);
        gie <= 1;
        apb(1, 8'h00, 8'h48);
        rd(8'h00, 8'he8);
        ack <= 1;
        @(posedge clk);
        ack <= 0;
        rd(8'h00, 8'h68);
        apb(1, 8'h0c, 8'h00);
        chk(32'(irq), 0);
        apb(1, 8'h08, 8'h03);
        rd(8'h04, 0);
        apb(1, 8'h0c, 8'h01);
        apb(1, 8'h00, 8'h68);
        rd(8'h00, 8'h48);
        $display("test slow rc done");
        sel_xt <= 1;
        apb(1, 8'h10, 8'h01);
        apb(1, 8'h00, 8'h00);
        run(63);
        rd(8'h04, 0);
        run(1);
        rd(8'h04, 8'h02);
        run(1000);
        rd(8'h04, 8'h02);
        $display("test stopped done");
        apb(1, 8'h08, 8'h03);
        apb(1, 8'h00, 8'h28);
        run(300);
        apb(1, 8'h00, 8'h18);
        run(1023);
        chk(32'(irq), 0);
        run(1);
        chk(32'(irq), 1);
        chk(32'(req), 0);
        rd(8'h00, 8'ha8);
        apb(1, 8'h00, 8'h88);
        rd(8'h00, 8'h28);
        apb(1, 8'h00, 8'h1f);
        rd(8'h00, 8'h2f);
        $display("test crystal done");
        end_sim();
    end
    initial begin
        #1000000;
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
